// >>> bench/tb_tcc_timer16.sv
// Purpose: self-checking bench for the 16-bit timer with capture
// Assumes: 100 MHz ref_clk, seed 73
// Notes: read bytes checked by a monitor from the model queue
`timescale 1ns/1ps
`default_nettype none
module tb_tcc_timer16;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cs = 3'h0;
  logic [3:0] mode = 4'h0;
  logic nfe = 1'b0, rise = 1'b1, csel = 1'b0, cie = 1'b0, oie = 1'b0;
  logic cclr = 1'b0, cack = 1'b0, oclr = 1'b0, oack = 1'b0;
  logic ext = 1'b0, pin = 1'b0, cmp = 1'b0, rd_d = 1'b0;
  wire [2:0] bus_addr;
  wire bus_wr, bus_rd;
  wire [7:0] bus_wdata, bus_rdata;
  wire [15:0] count, capv, cmpa, cmpb;
  wire top, bot, ovf, capf, oirq, cirq;
  int fail_count = 0, compares = 0, seed = 73, cyc_n = 0, lat0, lat1, n, e;
  int dv[5] = '{1, 8, 64, 256, 1024};
  logic [15:0] v, w;
  always #5 ref_clk = ~ref_clk;
  tcc_cpu_model i_tcc_cpu_model (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata));
  tcc_timer16 i_tcc_timer16 (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .clock_source_select(cs), .waveform_mode_select(mode), .noise_filter_enable(nfe),
    .capture_edge_rising(rise), .comparator_trigger_select(csel), .capture_irq_enable(cie),
    .overflow_irq_enable(oie), .capture_flag_clear(cclr), .capture_irq_ack(cack),
    .overflow_flag_clear(oclr), .overflow_irq_ack(oack), .external_count_pin(ext),
    .capture_pin(pin), .comparator_output(cmp), .count_value(count), .capture_value(capv),
    .compare_a_value(cmpa), .compare_b_value(cmpb), .top_flag(top), .bottom_flag(bot),
    .overflow_flag(ovf), .capture_flag(capf), .overflow_irq(oirq), .capture_irq(cirq));
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    compares++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fail_count++;
      $display("[FAIL] %0t count %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wait_sig(input int s, output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (!(s == 0 ? capf : s == 1 ? ovf : top) && k < 60);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (rd_d) chk({8'h00, bus_rdata}, {8'h00, i_tcc_cpu_model.exp_q.pop_front()});
    rd_d <= bus_rd && !bus_wr;
    cyc_n++;
    if (cyc_n > 5000) begin
      fail_count++;
      $display("[FAIL] %0t run too long", $time);
      tally_and_finish();
    end
  end
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    v = 16'($random(seed));
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CNT_L, v);
    #1 chk(count, v);
    cyc(4);
    #1 chk(count, v);
    i_tcc_cpu_model.rd16(tcc_pkg::ADDR_CNT_L, v);
    w = 16'($random(seed));
    i_tcc_cpu_model.wr8(tcc_pkg::ADDR_CMPA_H, w[15:8]);
    i_tcc_cpu_model.wr8(tcc_pkg::ADDR_CMPA_L, w[7:0]);
    i_tcc_cpu_model.wr8(tcc_pkg::ADDR_CMPB_L, ~w[7:0]);
    #1 chk(cmpa, w);
    chk(cmpb, {w[15:8], ~w[7:0]});
    i_tcc_cpu_model.rd8(tcc_pkg::ADDR_CMPA_H, w[15:8]);
    for (int k = 1; k < 8; k++) begin
      i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CNT_L, 16'h0000);
      cs <= 3'(k);
      for (int j = 0; j < 64; j++) begin
        ext <= ~ext;
        cyc(4);
      end
      cs <= tcc_pkg::CS_STOP;
      cyc(1);
      e = (k < 6) ? 256 / dv[k-1] : 32;
      #1 chk_rng(count, e - int'(k < 6 && e > 0), e + int'(k < 6));
    end
    @(posedge ref_clk);
    oie <= 1'b1;
    cs <= tcc_pkg::CS_DIV1;
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CNT_L, 16'hFFFD);
    #1 chk(count, 16'hFFFD);
    wait_sig(1, n);
    chk({13'h0, ovf, oirq, bot}, 16'h0007);
    @(posedge ref_clk);
    cs <= tcc_pkg::CS_STOP;
    mode <= tcc_pkg::WGM_FAST8;
    oack <= 1'b1;
    @(posedge ref_clk);
    oack <= 1'b0;
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CNT_L, 16'h00FC);
    chk({15'h0, ovf}, 16'h0000);
    cs <= tcc_pkg::CS_DIV1;
    wait_sig(2, n);
    chk(count, tcc_pkg::TOP_8BIT);
    cyc(1);
    #1 chk(count, 16'h0000);
    @(posedge ref_clk);
    cs <= tcc_pkg::CS_STOP;
    mode <= tcc_pkg::WGM_NORMAL;
    oclr <= 1'b1;
    v = 16'($random(seed));
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CNT_L, v);
    oclr <= 1'b0;
    chk({15'h0, ovf}, 16'h0000);
    cie <= 1'b1;
    pin <= 1'b1;
    wait_sig(0, lat0);
    chk({14'h0, capf, cirq}, 16'h0003);
    chk(capv, v);
    i_tcc_cpu_model.rd16(tcc_pkg::ADDR_CAP_L, v);
    rise <= 1'b0;
    nfe <= 1'b1;
    cclr <= 1'b1;
    @(posedge ref_clk);
    cclr <= 1'b0;
    pin <= 1'b0;
    #1 chk({15'h0, capf}, 16'h0000);
    wait_sig(0, n);
    chk({15'h0, capf}, 16'h0001);
    @(posedge ref_clk);
    cack <= 1'b1;
    rise <= 1'b1;
    pin <= 1'b1;
    @(posedge ref_clk);
    cack <= 1'b0;
    @(posedge ref_clk);
    pin <= 1'b0;
    cyc(12);
    #1 chk({15'h0, capf}, 16'h0000);
    @(posedge ref_clk);
    pin <= 1'b1;
    wait_sig(0, lat1);
    chk(16'(lat1), 16'(lat0 + 4));
    @(posedge ref_clk);
    csel <= 1'b1;
    nfe <= 1'b0;
    cyc(6);
    cclr <= 1'b1;
    @(posedge ref_clk);
    cclr <= 1'b0;
    cmp <= 1'b1;
    wait_sig(0, n);
    chk({15'h0, capf}, 16'h0001);
    @(posedge ref_clk);
    csel <= 1'b0;
    cclr <= 1'b1;
    mode <= tcc_pkg::WGM_CTC_CAP;
    pin <= 1'b0;
    @(posedge ref_clk);
    cclr <= 1'b0;
    cyc(4);
    pin <= 1'b1;
    cyc(12);
    #1 chk({15'h0, capf}, 16'h0000);
    @(posedge ref_clk);
    pin <= 1'b0;
    w = 16'($random(seed));
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CAP_L, w);
    #1 chk(capv, w);
    @(posedge ref_clk);
    mode <= tcc_pkg::WGM_NORMAL;
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CAP_L, ~w);
    #1 chk(capv, w);
    @(posedge ref_clk);
    mode <= tcc_pkg::WGM_PC8;
    i_tcc_cpu_model.wr16(tcc_pkg::ADDR_CNT_L, 16'h00FE);
    cs <= tcc_pkg::CS_DIV1;
    cyc(3);
    #1 chk(count, 16'h00FD);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> bench/tcc_cpu_model.sv
// Purpose: processor side of the byte bus
// Assumes: one strobe cycle per access
// Notes: expected read bytes queued in exp_q
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
  input wire logic ref_clk, // Clock
  output var logic [2:0] bus_addr = 3'h0, // Address
  output var logic bus_wr = 1'b0, // Write strobe
  output var logic bus_rd = 1'b0, // Read strobe
  output var logic [7:0] bus_wdata = 8'h00 // Write data
);
  logic [7:0] exp_q[$];
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask
  task automatic rd8(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr8(a + 3'h1, v[15:8]);
    wr8(a, v[7:0]);
  endtask
  task automatic rd16(input logic [2:0] a, input logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 3'h1, v[15:8]);
  endtask
endmodule
`default_nettype wire

// >>> bench/tcc_timer16_asserts.sv
// Purpose: port-level assertions for the 16-bit timer with capture
// Assumes: one clock domain, reset active low
// Notes: bound to tcc_timer16 below
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_asserts (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [2:0] bus_addr, // Address
  input wire logic bus_wr, // Write strobe
  input wire logic [7:0] bus_wdata, // Write data
  input wire logic [2:0] clock_source_select, // Clock select
  input wire logic [3:0] waveform_mode_select, // Mode
  input wire logic capture_irq_enable, // Capture enable
  input wire logic [15:0] count_value, // Counter
  input wire logic top_flag, // TOP
  input wire logic bottom_flag, // BOTTOM
  input wire logic overflow_flag, // Overflow
  input wire logic capture_flag, // Capture flag
  input wire logic capture_irq // Capture request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_stop_holds:
    assert property (clock_source_select == tcc_pkg::CS_STOP && !bus_wr |=> $stable(count_value))
    else $error("counter moved while stopped");
  a_div1_step:
    assert property (clock_source_select == tcc_pkg::CS_DIV1 && $stable(clock_source_select)
      && waveform_mode_select == tcc_pkg::WGM_NORMAL && $stable(waveform_mode_select) && !bus_wr
      |=> count_value == $past(count_value) + tcc_pkg::CNT_ONE) else $error("no unit step");
  a_write_wins:
    assert property (bus_wr && bus_addr == tcc_pkg::ADDR_CNT_L
      |=> count_value[7:0] == $past(bus_wdata)) else $error("low write lost");
  a_ovf_wrap:
    assert property (count_value == tcc_pkg::CNT_MAX && !bus_wr
      && clock_source_select == tcc_pkg::CS_DIV1 && waveform_mode_select == tcc_pkg::WGM_NORMAL
      |=> count_value == tcc_pkg::CNT_BOTTOM && overflow_flag) else $error("bad wrap");
  a_bottom_level:
    assert property (bottom_flag == (count_value == tcc_pkg::CNT_BOTTOM))
    else $error("bottom flag wrong");
  a_top_fast8:
    assert property (waveform_mode_select == tcc_pkg::WGM_FAST8 && $stable(waveform_mode_select)
      |-> top_flag == (count_value == tcc_pkg::TOP_8BIT)) else $error("top flag wrong");
  a_irq_follows:
    assert property (capture_irq == (capture_flag && $past(capture_irq_enable)))
    else $error("capture request mismatch");
  a_no_cap_top:
    assert property (waveform_mode_select[3] && !waveform_mode_select[0]
      && $stable(waveform_mode_select) |-> !$rose(capture_flag)) else $error("capture in top mode");
endmodule
bind tcc_timer16 tcc_timer16_asserts i_tcc_timer16_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
  .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
  .clock_source_select(clock_source_select), .waveform_mode_select(waveform_mode_select),
  .capture_irq_enable(capture_irq_enable), .count_value(count_value), .top_flag(top_flag),
  .bottom_flag(bottom_flag), .overflow_flag(overflow_flag), .capture_flag(capture_flag),
  .capture_irq(capture_irq));
`default_nettype wire

// >>> hdl/tcc_pkg.sv
// Purpose: constants for the 16-bit timer/counter with input capture
// Assumes: 8-bit processor data bus, byte locations decoded on a 3-bit address

package tcc_pkg;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CNT_L = 3'h0;
  localparam logic [2:0] ADDR_CNT_H = 3'h1;
  localparam logic [2:0] ADDR_CAP_L = 3'h2;
  localparam logic [2:0] ADDR_CAP_H = 3'h3;
  localparam logic [2:0] ADDR_CMPA_L = 3'h4;
  localparam logic [2:0] ADDR_CMPA_H = 3'h5;
  localparam logic [2:0] ADDR_CMPB_L = 3'h6;
  localparam logic [2:0] ADDR_CMPB_H = 3'h7;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_CMP = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_CMP = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'hA;
  localparam logic [3:0] WGM_PC_CMP = 4'hB;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;
  localparam logic [3:0] WGM_FAST_CAP = 4'hE;
  localparam logic [3:0] WGM_FAST_CMP = 4'hF;
  localparam int FILT_LEN = 4;
  typedef enum logic {TCC_UP, TCC_DOWN} tcc_dir_t;
endpackage

// >>> hdl/tcc_timer16.sv
// Purpose: 16-bit timer/counter core with input capture and byte bus access
// Assumes: all inputs synchronous to ref_clk except rst_n, the two capture sources and the external count pin
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module tcc_timer16 (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [2:0] bus_addr, // Byte location
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  input wire logic [7:0] bus_wdata, // Write data
  output logic [7:0] bus_rdata, // Read data, one cycle later
  input wire logic [2:0] clock_source_select, // Clock select
  input wire logic [3:0] waveform_mode_select, // Mode, split over ctrl A/B
  input wire logic noise_filter_enable, // Trigger noise filter on
  input wire logic capture_edge_rising, // 1 rising, 0 falling edge
  input wire logic comparator_trigger_select, // Use comparator output
  input wire logic capture_irq_enable, // Capture interrupt enable
  input wire logic overflow_irq_enable, // Overflow interrupt enable
  input wire logic capture_flag_clear, // Write-one clear
  input wire logic capture_irq_ack, // Capture interrupt serviced
  input wire logic overflow_flag_clear, // Write-one clear
  input wire logic overflow_irq_ack, // Overflow interrupt serviced
  input wire logic external_count_pin, // External clock pin
  input wire logic capture_pin, // Capture pin level
  input wire logic comparator_output, // Analog comparator output
  output logic [15:0] count_value, // Counter
  output logic [15:0] capture_value, // Capture register
  output logic [15:0] compare_a_value, // Compare A register
  output logic [15:0] compare_b_value, // Compare B register
  output logic top_flag, // Counter at TOP
  output logic bottom_flag, // Counter at zero
  output logic overflow_flag, // Overflow flag
  output logic capture_flag, // Capture flag
  output logic overflow_irq, // Overflow interrupt request
  output logic capture_irq // Capture interrupt request
);

  ////////////////////////////////////////////////////////////////
  // State
  logic [15:0] count_reg, count_next;
  logic [15:0] capture_reg, capture_next;
  logic [15:0] cmpa_reg, cmpa_next;
  logic [15:0] cmpb_reg, cmpb_next;
  logic [7:0] temp_reg, temp_next;
  logic [7:0] rdata_reg, rdata_next;
  tcc_pkg::tcc_dir_t dir_reg, dir_next;
  logic [9:0] pre_reg, pre_next;
  logic [1:0] ext_sync_reg;
  logic ext_prev_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [3:0] filt_hist_reg;
  logic filt_out_reg, filt_out_next;
  logic trig_prev_reg;
  logic top_reg, bottom_reg;
  logic ovf_reg, ovf_next;
  logic capf_reg, capf_next;
  logic ovf_irq_reg, capf_irq_reg;

  ////////////////////////////////////////////////////////////////
  // Bus decode
  wire wr_cnt_l = bus_wr && (bus_addr == tcc_pkg::ADDR_CNT_L);
  wire wr_cap_l = bus_wr && (bus_addr == tcc_pkg::ADDR_CAP_L);
  wire wr_cmpa_l = bus_wr && (bus_addr == tcc_pkg::ADDR_CMPA_L);
  wire wr_cmpb_l = bus_wr && (bus_addr == tcc_pkg::ADDR_CMPB_L);
  wire wr_high = bus_wr && bus_addr[0];
  wire rd_ok = bus_rd && !bus_wr;
  wire rd_cnt_l = rd_ok && (bus_addr == tcc_pkg::ADDR_CNT_L);
  wire rd_cap_l = rd_ok && (bus_addr == tcc_pkg::ADDR_CAP_L);
  wire [15:0] wr_word = {temp_reg, bus_wdata};

  ////////////////////////////////////////////////////////////////
  // Mode decode
  logic [15:0] top_val;
  logic dual_slope, ctc_mode, cap_top, cmp_top;
  always_comb begin
    top_val = tcc_pkg::CNT_MAX;
    dual_slope = 1'b0;
    ctc_mode = 1'b0;
    cap_top = 1'b0;
    cmp_top = 1'b0;
    case (waveform_mode_select)
      tcc_pkg::WGM_NORMAL: top_val = tcc_pkg::CNT_MAX;
      tcc_pkg::WGM_PC8: begin
        top_val = tcc_pkg::TOP_8BIT;
        dual_slope = 1'b1;
      end
      tcc_pkg::WGM_PC9: begin
        top_val = tcc_pkg::TOP_9BIT;
        dual_slope = 1'b1;
      end
      tcc_pkg::WGM_PC10: begin
        top_val = tcc_pkg::TOP_10BIT;
        dual_slope = 1'b1;
      end
      tcc_pkg::WGM_CTC_CMP: begin
        ctc_mode = 1'b1;
        cmp_top = 1'b1;
      end
      tcc_pkg::WGM_FAST8: top_val = tcc_pkg::TOP_8BIT;
      tcc_pkg::WGM_FAST9: top_val = tcc_pkg::TOP_9BIT;
      tcc_pkg::WGM_FAST10: top_val = tcc_pkg::TOP_10BIT;
      tcc_pkg::WGM_PFC_CAP, tcc_pkg::WGM_PC_CAP: begin
        dual_slope = 1'b1;
        cap_top = 1'b1;
      end
      tcc_pkg::WGM_PFC_CMP, tcc_pkg::WGM_PC_CMP: begin
        dual_slope = 1'b1;
        cmp_top = 1'b1;
      end
      tcc_pkg::WGM_CTC_CAP: begin
        ctc_mode = 1'b1;
        cap_top = 1'b1;
      end
      tcc_pkg::WGM_FAST_CAP: cap_top = 1'b1;
      tcc_pkg::WGM_FAST_CMP: cmp_top = 1'b1;
      default: top_val = tcc_pkg::CNT_MAX;
    endcase
    if (cap_top) begin
      top_val = capture_reg;
    end else if (cmp_top) begin
      top_val = cmpa_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Timer clock select
  wire ext_rise = ext_sync_reg[1] && !ext_prev_reg;
  wire ext_fall = !ext_sync_reg[1] && ext_prev_reg;
  logic tick;
  always_comb begin
    case (clock_source_select)
      tcc_pkg::CS_STOP: tick = 1'b0;
      tcc_pkg::CS_DIV1: tick = 1'b1;
      tcc_pkg::CS_DIV8: tick = (pre_reg & tcc_pkg::PRE_MASK_8) == tcc_pkg::PRE_MASK_8;
      tcc_pkg::CS_DIV64: tick = (pre_reg & tcc_pkg::PRE_MASK_64) == tcc_pkg::PRE_MASK_64;
      tcc_pkg::CS_DIV256: tick = (pre_reg & tcc_pkg::PRE_MASK_256) == tcc_pkg::PRE_MASK_256;
      tcc_pkg::CS_DIV1024: tick = pre_reg == tcc_pkg::PRE_MASK_1024;
      tcc_pkg::CS_EXT_FALL: tick = ext_fall;
      tcc_pkg::CS_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end
  assign pre_next = (clock_source_select == tcc_pkg::CS_STOP) ? '0 : pre_reg + 10'h001;

  ////////////////////////////////////////////////////////////////
  // Counter unit
  wire at_top = count_reg == top_val;
  wire at_bottom = count_reg == tcc_pkg::CNT_BOTTOM;
  always_comb begin
    count_next = count_reg;
    dir_next = dir_reg;
    if (wr_cnt_l) begin
      count_next = wr_word;
    end else if (tick) begin
      if (!dual_slope) begin
        dir_next = tcc_pkg::TCC_UP;
        count_next = at_top ? tcc_pkg::CNT_BOTTOM : count_reg + tcc_pkg::CNT_ONE;
      end else if (dir_reg == tcc_pkg::TCC_UP) begin
        if (count_reg >= top_val) begin
          dir_next = tcc_pkg::TCC_DOWN;
          count_next = count_reg - tcc_pkg::CNT_ONE;
        end else begin
          count_next = count_reg + tcc_pkg::CNT_ONE;
        end
      end else if (at_bottom) begin
        dir_next = tcc_pkg::TCC_UP;
        count_next = count_reg + tcc_pkg::CNT_ONE;
      end else begin
        count_next = count_reg - tcc_pkg::CNT_ONE;
      end
    end
  end

  wire ovf_event = tick && !wr_cnt_l && (
    (dual_slope && dir_reg == tcc_pkg::TCC_DOWN && at_bottom) ||
    (ctc_mode && count_reg == tcc_pkg::CNT_MAX) ||
    (!dual_slope && !ctc_mode && at_top));
  wire ovf_clr = overflow_flag_clear || overflow_irq_ack;
  assign ovf_next = ovf_event || (ovf_reg && !ovf_clr);

  ////////////////////////////////////////////////////////////////
  // Capture trigger path
  // source select after sync
  wire trig_raw = comparator_trigger_select ? cmp_sync_reg[1] : pin_sync_reg[1];
  wire filt_all_one = &filt_hist_reg;
  wire filt_all_zero = ~|filt_hist_reg;
  assign filt_out_next = filt_all_one ? 1'b1 : (filt_all_zero ? 1'b0 : filt_out_reg);
  wire trig_lvl = noise_filter_enable ? filt_out_next : trig_raw;
  wire trig_edge = capture_edge_rising ? (trig_lvl && !trig_prev_reg)
                                       : (!trig_lvl && trig_prev_reg);
  // only the selected edge counts, none while the capture reg sets TOP
  wire capture_evt = trig_edge && !cap_top;
  wire capf_clr = capture_flag_clear || capture_irq_ack;

  always_comb begin
    capture_next = capture_reg;
    if (wr_cap_l && cap_top) begin
      capture_next = wr_word;
    end else if (capture_evt) begin
      capture_next = count_reg;
    end
  end
  assign capf_next = capture_evt || (capf_reg && !capf_clr);

  ////////////////////////////////////////////////////////////////
  // Temporary register and read data
  always_comb begin
    temp_next = temp_reg;
    // high byte writes go to temp
    if (wr_high) begin
      temp_next = bus_wdata;
    end else if (rd_cnt_l) begin
      temp_next = count_reg[15:8];
    end else if (rd_cap_l) begin
      temp_next = capture_reg[15:8];
    end
  end

  // compare regs load from shared temp
  assign cmpa_next = wr_cmpa_l ? wr_word : cmpa_reg;
  assign cmpb_next = wr_cmpb_l ? wr_word : cmpb_reg;

  always_comb begin
    rdata_next = rdata_reg;
    if (rd_ok) begin
      case (bus_addr)
        tcc_pkg::ADDR_CNT_L: rdata_next = count_reg[7:0];
        tcc_pkg::ADDR_CAP_L: rdata_next = capture_reg[7:0];
        tcc_pkg::ADDR_CMPA_L: rdata_next = cmpa_reg[7:0];
        tcc_pkg::ADDR_CMPA_H: rdata_next = cmpa_reg[15:8];
        tcc_pkg::ADDR_CMPB_L: rdata_next = cmpb_reg[7:0];
        tcc_pkg::ADDR_CMPB_H: rdata_next = cmpb_reg[15:8];
        default: rdata_next = temp_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flip-flops
  // Counter, direction, prescaler, capture, compare, temp and read data store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      dir_reg <= tcc_pkg::TCC_UP;
      pre_reg <= '0;
      capture_reg <= '0;
      cmpa_reg <= '0;
      cmpb_reg <= '0;
      temp_reg <= '0;
      rdata_reg <= '0;
    end else begin
      count_reg <= count_next;
      dir_reg <= dir_next;
      pre_reg <= pre_next;
      capture_reg <= capture_next;
      cmpa_reg <= cmpa_next;
      cmpb_reg <= cmpb_next;
      temp_reg <= temp_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_reg <= '0;
      ext_prev_reg <= 1'b0;
      pin_sync_reg <= '0;
      cmp_sync_reg <= '0;
      filt_hist_reg <= '0;
      filt_out_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], external_count_pin};
      ext_prev_reg <= ext_sync_reg[1];
      pin_sync_reg <= {pin_sync_reg[0], capture_pin};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_output};
      filt_hist_reg <= {filt_hist_reg[2:0], trig_raw};
      filt_out_reg <= filt_out_next;
      trig_prev_reg <= trig_lvl;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      top_reg <= 1'b0;
      bottom_reg <= 1'b1;
      ovf_reg <= 1'b0;
      capf_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
      capf_irq_reg <= 1'b0;
    end else begin
      top_reg <= count_next == top_val;
      bottom_reg <= count_next == tcc_pkg::CNT_BOTTOM;
      ovf_reg <= ovf_next;
      capf_reg <= capf_next;
      ovf_irq_reg <= ovf_next && overflow_irq_enable;
      capf_irq_reg <= capf_next && capture_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign bus_rdata = rdata_reg;
  assign count_value = count_reg;
  assign capture_value = capture_reg;
  assign compare_a_value = cmpa_reg;
  assign compare_b_value = cmpb_reg;
  assign top_flag = top_reg;
  assign bottom_flag = bottom_reg;
  assign overflow_flag = ovf_reg;
  assign capture_flag = capf_reg;
  assign overflow_irq = ovf_irq_reg;
  assign capture_irq = capf_irq_reg;

endmodule

`default_nettype wire
